//--- src/acc_ops_pkg.sv
/*
  acc_ops_pkg: widths, opcodes, pointer update modes, states and reset values
  for the accumulator store and return execution block.
  Assumes a single core clock; the bench and the checker depend on the opcode values here.
*/
package acc_ops_pkg;

  // ============================================================
  // widths
  localparam int ACC_W     = 8;
  localparam int FILE_AW   = 7;
  localparam int PTR_W     = 16;
  localparam int OFS_W     = 6;
  localparam int PC_W      = 15;
  localparam int PTR_COUNT = 2;

  // ============================================================
  // file map: the two indirect access ports are no storage
  localparam logic [FILE_AW-1:0] FILE_ADDR_MAX = 7'h7F;
  localparam logic [FILE_AW-1:0] PORT0_ADDR    = 7'h00;
  localparam logic [FILE_AW-1:0] PORT1_ADDR    = 7'h01;

  // ============================================================
  // pointer update modes
  localparam logic [1:0] MODE_PRE_INC  = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC  = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;

  // ============================================================
  // operations
  typedef enum logic [2:0] {
    OP_NOP              = 3'h0,
    OP_STORE_DIRECT     = 3'h1,
    OP_STORE_INDIRECT   = 3'h2,
    OP_STORE_OFFSET     = 3'h3,
    OP_LOAD_PRESCALER   = 3'h4,
    OP_SOFT_RESET       = 3'h5,
    OP_RETURN           = 3'h6,
    OP_RETURN_FROM_IRQ  = 3'h7
  } op_t;

  // ============================================================
  // sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_READY    = 2'h1,
    ST_RET_TAIL = 2'h2
  } state_t;

  // ============================================================
  // reset values
  localparam logic [ACC_W-1:0] PRESCALER_RST = 8'hFF;
  localparam logic [PTR_W-1:0] PTR_RST       = 16'h0000;
  localparam logic             FLAG_N_RST    = 1'h1;

endpackage

//--- src/pointer_update.sv
/*
  pointer_update: effective address and next value of one indirect pointer.
  Assumes the caller picks offset form or a mode; purely combinational.
*/
`timescale 1ns/1ps
module pointer_update (
  // pointer and operand
  input  wire logic [acc_ops_pkg::PTR_W-1:0] ptr_i,
  input  wire logic [1:0]                    mode_i,
  input  wire logic                          offset_form_i,
  input  wire logic [acc_ops_pkg::OFS_W-1:0] offset_i,
  // results
  output logic      [acc_ops_pkg::PTR_W-1:0] addr_o,
  output logic      [acc_ops_pkg::PTR_W-1:0] next_o
);

  // ============================================================
  // arithmetic
  logic [acc_ops_pkg::PTR_W-1:0] inc;
  logic [acc_ops_pkg::PTR_W-1:0] dec;
  logic [acc_ops_pkg::PTR_W-1:0] rel;

  // carries out of bit 15 are dropped on purpose: wrap at the top and bottom
  assign inc = acc_ops_pkg::PTR_W'(ptr_i + 16'h0001);
  assign dec = acc_ops_pkg::PTR_W'(ptr_i - 16'h0001);
  assign rel = acc_ops_pkg::PTR_W'(ptr_i + {{(acc_ops_pkg::PTR_W-acc_ops_pkg::OFS_W){offset_i[acc_ops_pkg::OFS_W-1]}},
                                            offset_i});

  always_comb begin
    addr_o = ptr_i;
    next_o = ptr_i;
    if (offset_form_i) begin
      addr_o = rel;
      next_o = ptr_i;
    end else begin
      unique case (mode_i)
        acc_ops_pkg::MODE_PRE_INC: begin
          addr_o = inc;
          next_o = inc;
        end
        acc_ops_pkg::MODE_PRE_DEC: begin
          addr_o = dec;
          next_o = dec;
        end
        acc_ops_pkg::MODE_POST_INC: begin
          addr_o = ptr_i;
          next_o = inc;
        end
        acc_ops_pkg::MODE_POST_DEC: begin
          addr_o = ptr_i;
          next_o = dec;
        end
      endcase
    end
  end

endmodule

//--- src/acc_store_and_return_ops.sv
/*
  acc_store_and_return_ops: execution of accumulator stores (direct, indirect,
  prescaler), software reset, no-operation and the two returns.
  Assumes decode hands over one operation per accepted cycle, that the data
  memory and file registers take a write in the cycle it is shown, and that the
  stack pops on the pulse given here.
*/
// Notes on behaviour
// - a direct store writes the accumulator to file register 2..127, or through port 0 or 1 to memory, and touches no flag.
// - an indirect store updates its pointer by mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// - the offset form writes at pointer plus a signed offset of -32..31 and keeps the pointer.
// - each pointer is 16 bits wide and wraps modulo 65536 when stepped.
// - neither pointer stepping nor the indirect store changes any status flag.
// - the indirect access ports hold nothing; any access goes to memory at its pointer, two pairs.
// - the prescaler load copies the accumulator into the prescaler configuration, no flags.
// - the software reset requests a full device reset and clears the active-low reset indicator.
// - the return from interrupt pops the stack into the pc and sets the global irq enable in two cycles.
// - the return from subroutine pops the stack into the pc, no flags, in two cycles.
`timescale 1ns/1ps
module acc_store_and_return_ops (
  // clock and resets
  input  wire logic                              clk_i,
  input  wire logic                              sys_rst_i,
  input  wire logic                              por_rst_i,
  // operation from decode
  input  wire logic                              op_valid_i,
  input  wire acc_ops_pkg::op_t                  op_i,
  output logic                                   ready_o,
  // operands
  input  wire logic [acc_ops_pkg::ACC_W-1:0]     acc_i,
  input  wire logic [acc_ops_pkg::FILE_AW-1:0]   file_addr_i,
  input  wire logic                              ptr_sel_i,
  input  wire logic [1:0]                        mode_i,
  input  wire logic [acc_ops_pkg::OFS_W-1:0]     offset_i,
  // program flow
  input  wire logic [acc_ops_pkg::PC_W-1:0]      stack_top_i,
  output logic                                   stack_pop_o,
  output logic                                   pc_load_o,
  output logic      [acc_ops_pkg::PC_W-1:0]      pc_value_o,
  output logic                                   pc_advance_o,
  output logic                                   global_irq_enable_set_o,
  // file register write
  output logic                                   file_we_o,
  output logic      [acc_ops_pkg::FILE_AW-1:0]   file_waddr_o,
  output logic      [acc_ops_pkg::ACC_W-1:0]     file_wdata_o,
  // data memory write
  output logic                                   mem_we_o,
  output logic      [acc_ops_pkg::PTR_W-1:0]     mem_addr_o,
  output logic      [acc_ops_pkg::ACC_W-1:0]     mem_wdata_o,
  // pointer access from other instructions
  input  wire logic                              ptr_wr_i,
  input  wire logic                              ptr_wr_sel_i,
  input  wire logic [acc_ops_pkg::PTR_W-1:0]     ptr_wr_data_i,
  output logic      [acc_ops_pkg::PTR_W-1:0]     ptr0_o,
  output logic      [acc_ops_pkg::PTR_W-1:0]     ptr1_o,
  // prescaler configuration
  output logic      [acc_ops_pkg::ACC_W-1:0]     prescaler_cfg_o,
  // reset control and status
  input  wire logic                              reset_flag_set_i,
  output logic                                   soft_reset_req_o,
  output logic                                   soft_reset_indicator_flag_n_o,
  output logic                                   flags_we_o
);

  // ============================================================
  // acceptance
  acc_ops_pkg::state_t state_q;
  acc_ops_pkg::state_t state_d;
  logic                take;

  // the tail cycle of a return is the only stall
  assign ready_o = (state_q == acc_ops_pkg::ST_READY);
  assign take    = op_valid_i & ready_o;

  // no operation handled here writes a status flag
  assign flags_we_o = 1'h0;

  // ============================================================
  // pointers and their update logic
  logic [acc_ops_pkg::PTR_W-1:0] ptr_q    [acc_ops_pkg::PTR_COUNT];
  logic [acc_ops_pkg::PTR_W-1:0] ptr_d    [acc_ops_pkg::PTR_COUNT];
  logic [acc_ops_pkg::PTR_W-1:0] ptr_addr [acc_ops_pkg::PTR_COUNT];
  logic [acc_ops_pkg::PTR_W-1:0] ptr_next [acc_ops_pkg::PTR_COUNT];
  logic                          port_hit [acc_ops_pkg::PTR_COUNT];
  logic                          is_offset;

  assign is_offset = (op_i == acc_ops_pkg::OP_STORE_OFFSET);

  genvar g;
  generate
    for (g = 0; g < acc_ops_pkg::PTR_COUNT; g++) begin : g_ptr
      pointer_update u_upd (
        .ptr_i         (ptr_q[g]),
        .mode_i        (mode_i),
        .offset_form_i (is_offset),
        .offset_i      (offset_i),
        .addr_o        (ptr_addr[g]),
        .next_o        (ptr_next[g])
      );

      // a direct store aimed at an access port lands at that port's pointer
      assign port_hit[g] = (file_addr_i == ((g == 0) ? acc_ops_pkg::PORT0_ADDR : acc_ops_pkg::PORT1_ADDR));

      always_comb begin
        ptr_d[g] = ptr_q[g];
        if (take && (op_i == acc_ops_pkg::OP_STORE_INDIRECT) && (ptr_sel_i == 1'(g))) begin
          ptr_d[g] = ptr_next[g];
        end
        // a register write from another instruction takes precedence
        if (ptr_wr_i && (ptr_wr_sel_i == 1'(g))) begin
          ptr_d[g] = ptr_wr_data_i;
        end
      end

      always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          ptr_q[g] <= acc_ops_pkg::PTR_RST;
        end else begin
          ptr_q[g] <= ptr_d[g];
        end
      end
    end
  endgenerate

  assign ptr0_o = ptr_q[0];
  assign ptr1_o = ptr_q[1];

  // ============================================================
  // write ports
  logic                            file_we_q;
  logic                            file_we_d;
  logic [acc_ops_pkg::FILE_AW-1:0] file_waddr_q;
  logic [acc_ops_pkg::FILE_AW-1:0] file_waddr_d;
  logic                            mem_we_q;
  logic                            mem_we_d;
  logic [acc_ops_pkg::PTR_W-1:0]   mem_addr_q;
  logic [acc_ops_pkg::PTR_W-1:0]   mem_addr_d;
  logic [acc_ops_pkg::ACC_W-1:0]   wdata_q;
  logic [acc_ops_pkg::ACC_W-1:0]   wdata_d;
  logic [acc_ops_pkg::ACC_W-1:0]   prescaler_q;
  logic [acc_ops_pkg::ACC_W-1:0]   prescaler_d;

  always_comb begin
    file_we_d    = 1'h0;
    file_waddr_d = file_waddr_q;
    mem_we_d     = 1'h0;
    mem_addr_d   = mem_addr_q;
    wdata_d      = wdata_q;
    prescaler_d  = prescaler_q;
    if (take) begin
      unique case (op_i)
        acc_ops_pkg::OP_STORE_DIRECT: begin
          wdata_d = acc_i;
          if (port_hit[0] || port_hit[1]) begin
            mem_we_d   = 1'h1;
            mem_addr_d = port_hit[0] ? ptr_q[0] : ptr_q[1];
          end else begin
            file_we_d    = 1'h1;
            file_waddr_d = file_addr_i & acc_ops_pkg::FILE_ADDR_MAX;
          end
        end
        acc_ops_pkg::OP_STORE_INDIRECT,
        acc_ops_pkg::OP_STORE_OFFSET: begin
          mem_we_d   = 1'h1;
          mem_addr_d = ptr_sel_i ? ptr_addr[1] : ptr_addr[0];
          wdata_d    = acc_i;
        end
        acc_ops_pkg::OP_LOAD_PRESCALER: begin
          prescaler_d = acc_i;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      file_we_q    <= 1'h0;
      file_waddr_q <= 7'h00;
      mem_we_q     <= 1'h0;
      mem_addr_q   <= 16'h0000;
      wdata_q      <= 8'h00;
      prescaler_q  <= acc_ops_pkg::PRESCALER_RST;
    end else begin
      file_we_q    <= file_we_d;
      file_waddr_q <= file_waddr_d;
      mem_we_q     <= mem_we_d;
      mem_addr_q   <= mem_addr_d;
      wdata_q      <= wdata_d;
      prescaler_q  <= prescaler_d;
    end
  end

  assign file_we_o       = file_we_q;
  assign file_waddr_o    = file_waddr_q;
  assign file_wdata_o    = wdata_q;
  assign mem_we_o        = mem_we_q;
  assign mem_addr_o      = mem_addr_q;
  assign mem_wdata_o     = wdata_q;
  assign prescaler_cfg_o = prescaler_q;

  // ============================================================
  // program flow and return sequencer
  logic                         pop_q;
  logic                         pop_d;
  logic                         irq_en_q;
  logic                         irq_en_d;
  logic                         adv_q;
  logic                         adv_d;
  logic [acc_ops_pkg::PC_W-1:0] pc_q;
  logic [acc_ops_pkg::PC_W-1:0] pc_d;

  always_comb begin
    state_d = state_q;
    pop_d   = 1'h0;
    irq_en_d = 1'h0;
    adv_d   = 1'h0;
    pc_d    = pc_q;
    unique case (state_q)
      acc_ops_pkg::ST_READY: begin
        if (take) begin
          unique case (op_i)
            acc_ops_pkg::OP_RETURN: begin
              pop_d   = 1'h1;
              pc_d    = stack_top_i;
              state_d = acc_ops_pkg::ST_RET_TAIL;
            end
            acc_ops_pkg::OP_RETURN_FROM_IRQ: begin
              pop_d   = 1'h1;
              irq_en_d = 1'h1;
              pc_d    = stack_top_i;
              state_d = acc_ops_pkg::ST_RET_TAIL;
            end
            acc_ops_pkg::OP_SOFT_RESET: begin
              adv_d = 1'h0;
            end
            default: begin
              adv_d = 1'h1;
            end
          endcase
        end
      end
      acc_ops_pkg::ST_RET_TAIL: begin
        // second cycle of a return: the fetched word after it is discarded
        state_d = acc_ops_pkg::ST_READY;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= acc_ops_pkg::ST_READY;
      pop_q   <= 1'h0;
      irq_en_q <= 1'h0;
      adv_q   <= 1'h0;
      pc_q    <= 15'h0000;
    end else begin
      state_q <= state_d;
      pop_q   <= pop_d;
      irq_en_q <= irq_en_d;
      adv_q   <= adv_d;
      pc_q    <= pc_d;
    end
  end

  assign stack_pop_o  = pop_q;
  assign pc_load_o    = pop_q;
  assign pc_value_o   = pc_q;
  assign global_irq_enable_set_o = irq_en_q;
  assign pc_advance_o = adv_q;

  // ============================================================
  // software reset
  logic rst_req_q;
  logic rst_req_d;
  logic flag_n_q;
  logic flag_n_d;

  always_comb begin
    rst_req_d = take && (op_i == acc_ops_pkg::OP_SOFT_RESET);
    flag_n_d  = flag_n_q;
    if (reset_flag_set_i) begin
      flag_n_d = 1'h1;
    end
    // the reset event beats a same-cycle software set, so it is never missed
    if (rst_req_d) begin
      flag_n_d = 1'h0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rst_req_q <= 1'h0;
    end else begin
      rst_req_q <= rst_req_d;
    end
  end

  // only power-on resets this flag, to 1; the device reset it causes must not
  always_ff @(posedge clk_i or posedge por_rst_i) begin
    if (por_rst_i) begin
      flag_n_q <= acc_ops_pkg::FLAG_N_RST;
    end else begin
      flag_n_q <= flag_n_d;
    end
  end

  assign soft_reset_req_o              = rst_req_q;
  assign soft_reset_indicator_flag_n_o = flag_n_q;

endmodule

//--- tb/core_side_model.sv
/*
  core_side_model: hardware stack and program counter beside the block.
  Assumes the bench pushes return addresses before each return it issues.
*/
`timescale 1ns/1ps
module core_side_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // program flow from the block
  input  wire logic        stack_pop_o,
  input  wire logic        pc_load_o,
  input  wire logic        pc_advance_o,
  input  wire logic [14:0] pc_value_o,
  // stack top to the block
  output logic      [14:0] stack_top_i
);
  logic [14:0] stk [0:7];
  logic [2:0]  sp = 3'h0;
  logic [14:0] pc_q;

  // ============================================================
  // stack: empty slots are never written, so a stray pop shows up as unknown
  assign stack_top_i = stk[sp];

  task automatic push(logic [14:0] v);
    sp = sp + 3'h1;
    stk[sp] = v;
  endtask

  always @(posedge clk_i) begin
    if (stack_pop_o) begin
      sp <= sp - 3'h1;
    end
  end

  // ============================================================
  // program counter
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pc_q <= 15'h0000;
    end else if (pc_load_o) begin
      pc_q <= pc_value_o;
    end else if (pc_advance_o) begin
      pc_q <= pc_q + 15'h0001;
    end
  end
endmodule

//--- tb/acc_ops_assertions.sv
/*
  acc_ops_checker: timing and value rules at the block's ports.
  Assumes one clock domain and bind into the block's top module.
*/
`timescale 1ns/1ps
module acc_ops_checker (
  // clock and reset
  input wire logic             clk_i,
  input wire logic             sys_rst_i,
  // operation and operands
  input wire logic             op_valid_i,
  input wire acc_ops_pkg::op_t op_i,
  input wire logic             ready_o,
  input wire logic [7:0]       acc_i,
  input wire logic [6:0]       file_addr_i,
  input wire logic             ptr_sel_i,
  input wire logic [1:0]       mode_i,
  input wire logic [5:0]       offset_i,
  input wire logic             ptr_wr_i,
  // results
  input wire logic [14:0]      stack_top_i,
  input wire logic             stack_pop_o,
  input wire logic             pc_load_o,
  input wire logic [14:0]      pc_value_o,
  input wire logic             pc_advance_o,
  input wire logic             global_irq_enable_set_o,
  input wire logic             file_we_o,
  input wire logic [6:0]       file_waddr_o,
  input wire logic [7:0]       file_wdata_o,
  input wire logic             mem_we_o,
  input wire logic [15:0]      mem_addr_o,
  input wire logic [15:0]      ptr0_o,
  input wire logic [15:0]      ptr1_o,
  input wire logic [7:0]       prescaler_cfg_o,
  input wire logic             soft_reset_req_o,
  input wire logic             soft_reset_indicator_flag_n_o,
  input wire logic             flags_we_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // ============================================================
  // taken operations
  logic [7:0]  tk;
  logic [15:0] sp_q;
  assign tk   = (op_valid_i && ready_o) ? (8'h01 << op_i) : 8'h00;
  assign sp_q = ptr_sel_i ? ptr1_o : ptr0_o;

  // ============================================================
  // assertions
  a_direct_write: assert property (tk[1] && file_addr_i > 7'h01 |=> file_we_o && !mem_we_o &&
    file_waddr_o == $past(file_addr_i) && file_wdata_o == $past(acc_i)) else $error("direct store wrong");
  a_port_redirect: assert property (tk[1] && file_addr_i < 7'h02 |=> mem_we_o && !file_we_o &&
    mem_addr_o == $past(file_addr_i[0] ? ptr1_o : ptr0_o)) else $error("port access not redirected");
  a_pre_step: assert property (tk[2] && !mode_i[1] && !ptr_wr_i |=>
    mem_addr_o == $past(mode_i[0] ? sp_q - 16'h0001 : sp_q + 16'h0001) &&
    ($past(ptr_sel_i) ? ptr1_o : ptr0_o) == mem_addr_o) else $error("pre step wrong");
  a_post_step: assert property (tk[2] && mode_i[1] && !ptr_wr_i |=> mem_addr_o == $past(sp_q) &&
    ($past(ptr_sel_i) ? ptr1_o : ptr0_o) == $past(mode_i[0] ? sp_q - 16'h0001 : sp_q + 16'h0001))
    else $error("post step wrong");
  a_offset_keep: assert property (tk[3] && !ptr_wr_i |=> mem_we_o && $stable(ptr0_o) && $stable(ptr1_o) &&
    mem_addr_o == $past(sp_q + {{10{offset_i[5]}}, offset_i})) else $error("offset store wrong");
  a_no_flags: assert property (flags_we_o == 1'b0) else $error("flags written");
  a_prescale_load: assert property (tk[4] |=> prescaler_cfg_o == $past(acc_i) && !mem_we_o)
    else $error("prescaler load wrong");
  a_soft_reset: assert property (tk[5] |=> soft_reset_req_o && !soft_reset_indicator_flag_n_o &&
    !pc_advance_o) else $error("soft reset wrong");
  a_ret_pop: assert property (tk[6] || tk[7] |=> stack_pop_o && pc_load_o && !ready_o &&
    pc_value_o == $past(stack_top_i) ##1 ready_o) else $error("return wrong");
  a_irq_enable_cause: assert property (global_irq_enable_set_o == $past(tk[7])) else $error("irq enable wrong");
  a_nop_only: assert property (tk[0] |=> pc_advance_o && !file_we_o && !mem_we_o && !stack_pop_o)
    else $error("nop side effect");

  // ============================================================
  // covers
  c_irq_ret: cover property (tk[7]);
  c_post_dec: cover property (tk[2] && mode_i == 2'h3);
  c_soft: cover property (tk[5]);
endmodule

bind acc_store_and_return_ops acc_ops_checker u_chk (.*);

//--- tb/acc_store_and_return_ops_tb.sv
/*
  acc_store_and_return_ops_tb: directed corners and seeded random operations.
  Assumes the block answers one cycle after the taking edge.
*/
`timescale 1ns/1ps
module acc_store_and_return_ops_tb;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, por_rst_i = 1'b1, op_valid_i = 1'b0, ptr_sel_i = 1'b0;
  logic ptr_wr_i = 1'b0, ptr_wr_sel_i = 1'b0, reset_flag_set_i = 1'b0, ready_o, stack_pop_o, pc_load_o;
  logic pc_advance_o, file_we_o, mem_we_o, soft_reset_req_o, soft_reset_indicator_flag_n_o;
  logic flags_we_o, global_irq_enable_set_o;
  acc_ops_pkg::op_t op_i = acc_ops_pkg::OP_NOP;
  logic [7:0]  acc_i = 8'h00, file_wdata_o, mem_wdata_o, prescaler_cfg_o, epre = 8'hFF;
  logic [6:0]  file_addr_i = 7'h00, file_waddr_o;
  logic [1:0]  mode_i = 2'h0;
  logic [5:0]  offset_i = 6'h00;
  logic [14:0] stack_top_i, pc_value_o, epc = 15'h0000;
  logic [15:0] ptr_wr_data_i = 16'h0000, mem_addr_o, ptr0_o, ptr1_o, ep [2] = '{16'h0000, 16'h0000};
  logic        ef = 1'b1;
  logic [31:0] r;
  int          n_mismatch = 0, checked = 0;

  acc_store_and_return_ops u_dut (.*);
  core_side_model u_far (.*);

  always #5 clk_i = ~clk_i;

  // ============================================================
  // expectation functions
  function automatic logic [15:0] addr_f(logic ofs, logic [15:0] p, logic [1:0] m, logic [5:0] k);
    if (ofs) return p + {{10{k[5]}}, k};
    return (m == 2'h0) ? p + 16'h0001 : (m == 2'h1) ? p - 16'h0001 : p;
  endfunction

  // ============================================================
  // tasks
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic end_sim;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr_ptr(logic s, logic [15:0] v);
    @(posedge clk_i);
    ptr_wr_i <= 1'b1;
    ptr_wr_sel_i <= s;
    ptr_wr_data_i <= v;
    @(posedge clk_i);
    ptr_wr_i <= 1'b0;
    ep[s] = v;
  endtask

  // one operation, checked in its answer cycle and in the cycle after
  task automatic do_op(logic [2:0] c, logic [7:0] a, logic [6:0] f, logic s, logic [1:0] m, logic [5:0] k);
    logic [15:0] ea;
    logic        mw;
    logic        rt;
    logic [14:0] t;
    rt = c > 3'h5;
    mw = c == 3'h2 || c == 3'h3 || (c == 3'h1 && f < 7'h02);
    ea = (c == 3'h1) ? ep[f[0]] : addr_f(c == 3'h3, ep[s], m, k);
    if (c == 3'h2) ep[s] = m[0] ? ep[s] - 16'h0001 : ep[s] + 16'h0001;
    if (c == 3'h4) epre = a;
    if (c == 3'h5) ef = 1'b0;
    t = u_far.stk[u_far.sp];
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    op_i <= acc_ops_pkg::op_t'(c);
    acc_i <= a;
    file_addr_i <= f;
    ptr_sel_i <= s;
    mode_i <= m;
    offset_i <= k;
    @(posedge clk_i);
    // a return keeps a request up through its tail cycle, which must refuse it
    op_valid_i <= rt;
    if (rt) op_i <= acc_ops_pkg::OP_NOP;
    #1;
    chk("file_we", c == 3'h1 && f > 7'h01, file_we_o);
    if (c == 3'h1 && f > 7'h01) chk("file_w", {f, a}, {file_waddr_o, file_wdata_o});
    chk("mem_we", mw, mem_we_o);
    if (mw) chk("mem_addr", ea, mem_addr_o);
    if (mw) chk("mem_data", a, mem_wdata_o);
    chk("ptr0", ep[0], ptr0_o);
    chk("ptr1", ep[1], ptr1_o);
    chk("prescaler", epre, prescaler_cfg_o);
    chk("flags_we", 1'b0, flags_we_o);
    chk("pop", rt, stack_pop_o);
    chk("pc_load", rt, pc_load_o);
    chk("irq_enable", c == 3'h7, global_irq_enable_set_o);
    chk("soft_req", c == 3'h5, soft_reset_req_o);
    chk("flag_n", ef, soft_reset_indicator_flag_n_o);
    if (rt) begin
      chk("pc_value", t, pc_value_o);
      chk("ready", 1'b0, ready_o);
      epc = t;
    end else if (c != 3'h5) begin
      epc = epc + 15'h0001;
    end
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    #1;
    chk("pc", epc, u_far.pc_q);
    if (rt) chk("refused", 1'b0, pc_advance_o);
    if (rt) chk("ready_back", 1'b1, ready_o);
  endtask

  // ============================================================
  // main sequence
  initial begin
    void'($urandom(32'h89C0));
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    por_rst_i <= 1'b0;
    #1;
    chk("ready", 1'b1, ready_o);
    wr_ptr(1'b0, 16'hFFFF);
    wr_ptr(1'b1, 16'h0000);
    // every mode; the first two wrap across the 16-bit boundary
    for (int i = 0; i < 4; i++) do_op(3'h2, 8'hA5, 7'h00, i[0], i[1:0], 6'h00);
    do_op(3'h3, 8'h3C, 7'h00, 1'b0, 2'h0, 6'h20);
    do_op(3'h3, 8'hC3, 7'h00, 1'b1, 2'h0, 6'h1F);
    for (int i = 0; i < 4; i++) do_op(3'h1, 8'h5A, (i == 3) ? 7'h7F : i[6:0], 1'b0, 2'h0, 6'h00);
    do_op(3'h4, 8'h4F, 7'h00, 1'b0, 2'h0, 6'h00);
    u_far.push(15'h7FFF);
    u_far.push(15'h0123);
    do_op(3'h7, 8'h00, 7'h00, 1'b0, 2'h0, 6'h00);
    do_op(3'h6, 8'h00, 7'h00, 1'b0, 2'h0, 6'h00);
    for (int i = 0; i < 80; i++) begin
      r = $urandom;
      if (r[31]) wr_ptr(r[30], r[15:0]);
      r = $urandom;
      if (r[26:24] > 3'h5) u_far.push(r[30:16]);
      do_op((r[26:24] == 3'h5) ? 3'h0 : r[26:24], r[7:0], r[14:8], r[15], r[17:16], r[23:18]);
    end
    // software reset, then the device reset it asks for
    do_op(3'h5, 8'h00, 7'h00, 1'b0, 2'h0, 6'h00);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    ep = '{16'h0000, 16'h0000};
    epre = 8'hFF;
    epc = 15'h0000;
    do_op(3'h0, 8'h00, 7'h00, 1'b0, 2'h0, 6'h00);
    @(posedge clk_i);
    reset_flag_set_i <= 1'b1;
    @(posedge clk_i);
    reset_flag_set_i <= 1'b0;
    ef = 1'b1;
    do_op(3'h0, 8'h00, 7'h00, 1'b0, 2'h0, 6'h00);
    end_sim;
  end

  // about 96 operations of at most five cycles each; the limit of 7000 cycles is some fourteen times that
  initial begin
    #(7000 * 10);
    n_mismatch++;
    end_sim;
  end
endmodule
